// ---- core/sps_top.sv ----
// Stepper phase sequencer with APB control and status
`timescale 1ns/1ps
`default_nettype none
`include "sps_cfg.svh"

module sps_top
    import sps_pkg::*;
(
    input wire logic pclk,                   // System clock, 250 MHz
    input wire logic presetn,                // Asynchronous reset, active low
    input wire logic psel,                   // APB select
    input wire logic penable,                // APB access phase
    input wire logic pwrite,                 // APB write
    input wire logic [`SPS_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata,          // APB write data
    input wire logic [3:0] pstrb,            // APB byte strobes
    output logic [31:0] prdata,              // APB read data
    output logic pready,                     // APB ready
    output logic pslverr,                    // APB error on unmapped address
    input wire logic step_clock,             // Step clock pin
    input wire logic excitation_mode,        // Mode pin, high half-step
    input wire logic direction_select,       // Direction pin, high reverse
    input wire logic sequencer_clear_n,      // Clear pin, active low
    input wire logic output_enable,          // Enable pin, active high
    output logic winding1_fwd,               // Winding 1 forward gate
    output logic winding2_fwd,               // Winding 2 forward gate
    output logic winding1_rev,               // Winding 1 reverse gate
    output logic winding2_rev                // Winding 2 reverse gate
);

    // ----------------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------------
    function automatic sps_win_t sps_phase(input sps_pos_t p);
        case (p)
            3'h0: sps_phase = `SPS_PH0;
            3'h1: sps_phase = `SPS_PH1;
            3'h2: sps_phase = `SPS_PH2;
            3'h3: sps_phase = `SPS_PH3;
            3'h4: sps_phase = `SPS_PH4;
            3'h5: sps_phase = `SPS_PH5;
            3'h6: sps_phase = `SPS_PH6;
            default: sps_phase = `SPS_PH7;
        endcase
    endfunction

    // Full step jumps two positions; from an odd position it lands on the next even one
    function automatic sps_pos_t sps_advance(input sps_pos_t p, input logic half,
                                             input logic rev);
        sps_pos_t delta;
        delta = (half || p[0]) ? 3'h1 : 3'h2;
        if (rev) begin
            sps_advance = p - delta;
        end else begin
            sps_advance = p + delta;
        end
    endfunction

    // ----------------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------------
    logic [4:0] pins_s;
    logic step_s;
    logic mode_s;
    logic dir_s;
    logic clear_n_s;
    logic enable_s;

    sps_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({step_clock, excitation_mode, direction_select, sequencer_clear_n,
            output_enable}),
        .q(pins_s)
    );

    assign {step_s, mode_s, dir_s, clear_n_s, enable_s} = pins_s;

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    sps_state_t state_reg;
    sps_state_t state_next;
    logic step_rise;
    logic clear_act;
    logic enable_eff;
    logic setup;
    logic wr_access;
    logic [`SPS_ADDR_W-1:0] addr_word;

    assign step_rise = step_s && !state_reg.step_prev;
    assign clear_act = !clear_n_s || state_reg.soft_clr;
    assign enable_eff = enable_s && state_reg.soft_en;
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;
    assign addr_word = {paddr[`SPS_ADDR_W-1:2], 2'b00};

    always_comb begin
        state_next = state_reg;
        state_next.step_prev = step_s;
        if (clear_act) begin
            state_next.pos = `SPS_POS_RST;
        end else if (step_rise && enable_eff) begin
            state_next.mode_q = mode_s;
            state_next.dir_q = dir_s;
            state_next.pos = sps_advance(state_reg.pos, mode_s, dir_s);
            state_next.count = state_reg.count + 16'h0001;
        end
        if (clear_act || !enable_eff) begin
            state_next.win = `SPS_WIN_OFF;
        end else begin
            state_next.win = sps_phase(state_next.pos);
        end

        // Zero-wait APB: data fetched in setup, answered in the access cycle
        state_next.pready = setup;
        if (setup) begin
            state_next.pslverr = 1'b0;
            state_next.prdata = 32'h0000_0000;
            case (addr_word)
                `SPS_CTRL_OFS: begin
                    state_next.prdata[`SPS_CTRL_EN_BIT] = state_reg.soft_en;
                    state_next.prdata[`SPS_CTRL_CLR_BIT] = state_reg.soft_clr;
                end
                `SPS_STATUS_OFS: begin
                    state_next.prdata[`SPS_ST_POS_LSB +: 3] = state_reg.pos;
                    state_next.prdata[`SPS_ST_MODE_BIT] = state_reg.mode_q;
                    state_next.prdata[`SPS_ST_DIR_BIT] = state_reg.dir_q;
                    state_next.prdata[`SPS_ST_WIN_LSB +: 4] = state_reg.win;
                    state_next.prdata[`SPS_ST_CLR_BIT] = clear_act;
                    state_next.prdata[`SPS_ST_EN_BIT] = enable_eff;
                end
                `SPS_COUNT_OFS: begin
                    state_next.prdata[15:0] = state_reg.count;
                end
                default: begin
                    state_next.pslverr = 1'b1;
                end
            endcase
        end else begin
            state_next.pslverr = 1'b0;
        end
        if (wr_access && pstrb[0] && addr_word == `SPS_CTRL_OFS) begin
            state_next.soft_en = pwdata[`SPS_CTRL_EN_BIT];
            state_next.soft_clr = pwdata[`SPS_CTRL_CLR_BIT];
        end
    end

    // ----------------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.step_prev <= 1'b0;
            state_reg.pos <= `SPS_POS_RST;
            state_reg.mode_q <= 1'b0;
            state_reg.dir_q <= 1'b0;
            state_reg.win <= `SPS_WIN_OFF;
            state_reg.soft_en <= `SPS_CTRL_EN_RST;
            state_reg.soft_clr <= `SPS_CTRL_CLR_RST;
            state_reg.count <= 16'h0000;
            state_reg.prdata <= 32'h0000_0000;
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign {winding1_fwd, winding2_fwd, winding1_rev, winding2_rev} = state_reg.win;
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic run;
    assign run = step_rise && enable_eff && !clear_act;

    step_advance_a: assert property (run |=> state_reg.pos != $past(state_reg.pos))
        else $error("step rise did not move the sequence");
    mode_sample_a: assert property (run |=> state_reg.mode_q == $past(mode_s)
                                    && state_reg.dir_q == $past(dir_s))
        else $error("mode or direction not taken at step rise");
    half_step_a: assert property (run && mode_s && !dir_s
                                  |=> state_reg.pos == $past(state_reg.pos) + 3'h1)
        else $error("half step did not move one position");
    full_even_a: assert property (run && !mode_s |=> !state_reg.pos[0])
        else $error("full step left an odd position");
    reverse_order_a: assert property (run && !mode_s && dir_s && !state_reg.pos[0]
                                      |=> state_reg.pos == $past(state_reg.pos) - 3'h2)
        else $error("reverse full step wrong");
    clear_off_a: assert property (clear_act |=> state_reg.win == `SPS_WIN_OFF
                                  && state_reg.pos == `SPS_POS_RST)
        else $error("clear did not reset and cut windings");
    init_step_a: assert property ($fell(clear_act) && enable_eff && !step_rise
                                  |=> state_reg.win == `SPS_PH0)
        else $error("first step after clear is wrong");
    enable_off_a: assert property (!enable_eff |=> state_reg.win == `SPS_WIN_OFF)
        else $error("windings on while disabled");
    hold_pos_a: assert property (!enable_eff && !clear_act
                                 |=> state_reg.pos == $past(state_reg.pos))
        else $error("position moved while disabled");
    win_match_a: assert property (enable_eff && !clear_act ##1 enable_eff && !clear_act
                                  |-> state_reg.win == sps_phase(state_reg.pos))
        else $error("windings do not match position");
    apb_ready_a: assert property (setup |=> pready ##1 !pready)
        else $error("APB access not one cycle");

    full_cycle_c: cover property (run && !mode_s && !dir_s);
    half_rev_c: cover property (run && mode_s && dir_s);
    disable_resume_c: cover property (!enable_eff ##1 enable_eff ##[1:8] state_reg.win != `SPS_WIN_OFF);
    unmapped_c: cover property (pready && pslverr);

endmodule

`default_nettype wire

// ---- common/sps_cfg.svh ----
// Constants of the stepper phase sequencer: offsets, fields, reset values, timing
// What this block does
// - Each step clock rise advances exactly one step while enabled and not cleared
// - Direction and mode sampled at step rise
// - Mode low full-step, high half-step
// - Direction low forward, high reverse
// - Clear low resets sequence, windings off
// - Reset starts at winding1_fwd plus winding2_rev
// - Enable low forces all windings off
// - Enable low keeps position; resumes same step
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define SPS_ADDR_W 12
`define SPS_CTRL_OFS 12'h000
`define SPS_STATUS_OFS 12'h004
`define SPS_COUNT_OFS 12'h008

// CTRL fields
`define SPS_CTRL_EN_BIT 0
`define SPS_CTRL_CLR_BIT 1
`define SPS_CTRL_EN_RST 1'b1
`define SPS_CTRL_CLR_RST 1'b0

// STATUS fields
`define SPS_ST_POS_LSB 0
`define SPS_ST_MODE_BIT 3
`define SPS_ST_DIR_BIT 4
`define SPS_ST_WIN_LSB 5
`define SPS_ST_CLR_BIT 9
`define SPS_ST_EN_BIT 10

// ----------------------------------------------------------------------
// Phase patterns {winding1_fwd, winding2_fwd, winding1_rev, winding2_rev}
// ----------------------------------------------------------------------
`define SPS_PH0 4'h9
`define SPS_PH1 4'h8
`define SPS_PH2 4'hc
`define SPS_PH3 4'h4
`define SPS_PH4 4'h6
`define SPS_PH5 4'h2
`define SPS_PH6 4'h3
`define SPS_PH7 4'h1
`define SPS_WIN_OFF 4'h0
`define SPS_POS_RST 3'h0

// ----------------------------------------------------------------------
// Timing of the far side
// ----------------------------------------------------------------------
`define SPS_CLK_MHZ 250
`define SPS_STEP_MAX_KHZ 50
`define SPS_CLEAR_MIN_NS 10000
`define SPS_DIR_HOLD_NS 6250
`define SPS_MODE_HOLD_NS 5000
`define SPS_STEP_WIDTH_NS 10000
`define SPS_STEP_WIDTH_CYC ((`SPS_STEP_WIDTH_NS * `SPS_CLK_MHZ + 999) / 1000)
`define SPS_MODE_HOLD_CYC ((`SPS_MODE_HOLD_NS * `SPS_CLK_MHZ + 999) / 1000)

`endif

// ---- common/sps_pkg.sv ----
// Types of the stepper phase sequencer
package sps_pkg;

    typedef logic [2:0] sps_pos_t;
    typedef logic [3:0] sps_win_t;

    typedef struct packed {
        logic step_prev;
        sps_pos_t pos;
        logic mode_q;
        logic dir_q;
        sps_win_t win;
        logic soft_en;
        logic soft_clr;
        logic [15:0] count;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sps_state_t;

endpackage

// ---- core/sps_sync.sv ----
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module sps_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk,               // Sampling clock
    input wire logic rst_n,             // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] d,     // Asynchronous pin levels
    output logic [WIDTH-1:0] q          // Synchronised levels
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ---- dv/sps_ctl_model.sv ----
// Motion controller model driving the step, direction, mode, clear and enable pins
`timescale 1ns/1ps
`default_nettype none
`include "sps_cfg.svh"

module sps_ctl_model #(
    parameter int WIDTH_CYC = `SPS_STEP_WIDTH_CYC,
    parameter int HOLD_CYC = (`SPS_DIR_HOLD_NS * `SPS_CLK_MHZ + 999) / 1000,
    parameter int CLEAR_CYC = `SPS_CLEAR_MIN_NS * `SPS_CLK_MHZ / 1000
) (
    input wire logic pclk,              // Timing clock
    output logic step_clock,            // Step pin
    output logic excitation_mode,       // Mode pin
    output logic direction_select,      // Direction pin
    output logic sequencer_clear_n,     // Clear pin, active low
    output logic output_enable          // Enable pin
);
    // One step takes a full period at the highest legal step rate
    localparam int PERIOD_CYC = `SPS_CLK_MHZ * 1000 / `SPS_STEP_MAX_KHZ;
    localparam int TAIL_CYC = PERIOD_CYC - HOLD_CYC - WIDTH_CYC;

    initial begin
        step_clock = 1'b0;
        excitation_mode = 1'b0;
        direction_select = 1'b0;
        sequencer_clear_n = 1'b0;
        output_enable = 1'b1;
    end

    // Direction and mode settle before the rise and stay through the pulse
    task automatic step(input logic dir, input logic mode);
        @(posedge pclk);
        direction_select <= dir;
        excitation_mode <= mode;
        repeat (HOLD_CYC) @(posedge pclk);
        step_clock <= 1'b1;
        repeat (WIDTH_CYC) @(posedge pclk);
        step_clock <= 1'b0;
        repeat (TAIL_CYC) @(posedge pclk);
    endtask

    task automatic clear();
        @(posedge pclk);
        sequencer_clear_n <= 1'b0;
        repeat (CLEAR_CYC) @(posedge pclk);
        sequencer_clear_n <= 1'b1;
    endtask

    task automatic set_en(input logic en);
        @(posedge pclk);
        output_enable <= en;
    endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sps_cfg.svh"

module testbench
    import sps_pkg::*;
;
    typedef struct packed {
        logic dir;
        logic mode;
        sps_win_t win;
    } sps_row_t;
    localparam int ROWS = 14;
    localparam int CEIL = 98000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`SPS_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic step_clock, excitation_mode, direction_select, sequencer_clear_n, output_enable;
    logic w1f, w2f, w1r, w2r;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    sps_row_t rows [ROWS] = '{
        '{1'b0, 1'b0, `SPS_PH2}, '{1'b0, 1'b0, `SPS_PH4}, '{1'b0, 1'b0, `SPS_PH6},
        '{1'b0, 1'b0, `SPS_PH0}, '{1'b0, 1'b1, `SPS_PH1}, '{1'b0, 1'b1, `SPS_PH2},
        '{1'b1, 1'b1, `SPS_PH1}, '{1'b1, 1'b1, `SPS_PH0}, '{1'b1, 1'b1, `SPS_PH7},
        '{1'b1, 1'b0, `SPS_PH6}, '{1'b1, 1'b0, `SPS_PH4}, '{1'b0, 1'b0, `SPS_PH6},
        '{1'b0, 1'b1, `SPS_PH7}, '{1'b0, 1'b0, `SPS_PH0}};

    always #2 pclk = ~pclk;

    sps_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .step_clock(step_clock),
        .excitation_mode(excitation_mode), .direction_select(direction_select),
        .sequencer_clear_n(sequencer_clear_n), .output_enable(output_enable),
        .winding1_fwd(w1f), .winding2_fwd(w2f), .winding1_rev(w1r), .winding2_rev(w2r));

    sps_ctl_model u_ctl (.pclk(pclk),
        .step_clock(step_clock), .excitation_mode(excitation_mode),
        .direction_select(direction_select), .sequencer_clear_n(sequencer_clear_n),
        .output_enable(output_enable));

    // ----------------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_win(input sps_win_t exp);
        chk("windings", {28'h0, w1f, w2f, w1r, w2r}, {28'h0, exp});
    endtask

    task automatic apb(input logic wr, input logic [`SPS_ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic err;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SPS_CTRL_OFS, 32'h0, rd, err);
        chk("ctrl reset", rd, 32'h1);
        chk_win(`SPS_WIN_OFF);
        u_ctl.clear();
        repeat (5) @(posedge pclk);
        chk_win(`SPS_PH0);
        $display("test reset done");
        for (int i = 0; i < ROWS; i++) begin
            u_ctl.step(rows[i].dir, rows[i].mode);
            chk_win(rows[i].win);
        end
        apb(1'b0, `SPS_STATUS_OFS, 32'h0, rd, err);
        chk("status", rd, {21'h0, 2'b10, `SPS_PH0, 5'h00});
        apb(1'b0, `SPS_COUNT_OFS, 32'h0, rd, err);
        chk("count", rd, 32'h0000000e);
        $display("test sequence done");
        u_ctl.step(1'b0, 1'b0);
        u_ctl.set_en(1'b0);
        repeat (5) @(posedge pclk);
        chk_win(`SPS_WIN_OFF);
        u_ctl.step(1'b0, 1'b0);
        chk_win(`SPS_WIN_OFF);
        u_ctl.set_en(1'b1);
        repeat (5) @(posedge pclk);
        chk_win(`SPS_PH2);
        apb(1'b1, `SPS_CTRL_OFS, 32'h0, rd, err);
        repeat (3) @(posedge pclk);
        chk_win(`SPS_WIN_OFF);
        apb(1'b1, `SPS_CTRL_OFS, 32'h1, rd, err);
        repeat (3) @(posedge pclk);
        chk_win(`SPS_PH2);
        $display("test enable done");
        fork
            u_ctl.clear();
            begin
                repeat (10) @(posedge pclk);
                chk_win(`SPS_WIN_OFF);
            end
        join
        repeat (5) @(posedge pclk);
        chk_win(`SPS_PH0);
        u_ctl.step(1'b0, 1'b1);
        apb(1'b1, `SPS_CTRL_OFS, 32'h3, rd, err);
        repeat (3) @(posedge pclk);
        chk_win(`SPS_WIN_OFF);
        apb(1'b1, `SPS_CTRL_OFS, 32'h1, rd, err);
        repeat (3) @(posedge pclk);
        chk_win(`SPS_PH0);
        $display("test clear done");
        apb(1'b1, `SPS_STATUS_OFS, 32'hffffffff, rd, err);
        chk("status write err", {31'h0, err}, 32'h0);
        apb(1'b0, 12'h00c, 32'h0, rd, err);
        chk("unmapped read err", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h00c, 32'h0, rd, err);
        chk("unmapped write err", {31'h0, err}, 32'h1);
        pstrb <= 4'he;
        apb(1'b1, `SPS_CTRL_OFS, 32'h0, rd, err);
        pstrb <= 4'hf;
        apb(1'b0, `SPS_CTRL_OFS, 32'h0, rd, err);
        chk("ctrl strobe off", rd, 32'h1);
        $display("test bus done");
        u_ctl.step(1'b0, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk_win(`SPS_WIN_OFF);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        chk_win(`SPS_PH0);
        $display("test second reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
